// ===== rtl/pcr_channel_bank.v
// configuration register set of one output channel with factory restore
`timescale 1ns/1ps
`include "pcr_regs.vh"
module pcr_channel_bank #(
    parameter [15:0] CUR_LIMIT_DEF = 16'h03e8
) (
    input  wire        core_clk_i,
    input  wire        nrst_i,
    input  wire        wr_en_i,
    input  wire [5:0]  wr_reg_i,
    input  wire [15:0] wr_data_i,
    input  wire        restore_i,
    input  wire [5:0]  rd_reg_i,
    output reg  [15:0] rd_data_o,
    output wire [15:0] feature_o,
    output wire [15:0] fallback_o
);
    reg  [15:0] cfg [0:`PCR_CFG_COUNT-1];
    wire [5:0]  wr_idx = wr_reg_i - `PCR_CFG_FIRST;
    wire [5:0]  rd_idx = rd_reg_i - `PCR_CFG_FIRST;
    wire        wr_hit = (wr_reg_i >= `PCR_CFG_FIRST) && (wr_idx < `PCR_CFG_COUNT);
    wire        rd_hit = (rd_reg_i >= `PCR_CFG_FIRST) && (rd_idx < `PCR_CFG_COUNT);
    integer     i;

    // factory value of each slot
    function [15:0] factory;
        input integer idx;
        begin
            case (idx)
                2:       factory = `PCR_DEF_GAIN;
                4:       factory = CUR_LIMIT_DEF;
                12:      factory = `PCR_DEF_AREA;
                default: factory = `PCR_DEF_ZERO;
            endcase
        end
    endfunction

    // storage; restore has priority over a write
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (i = 0; i < `PCR_CFG_COUNT; i = i + 1) begin
                cfg[i] <= factory(i);
            end
        end else if (restore_i) begin
            for (i = 0; i < `PCR_CFG_COUNT; i = i + 1) begin
                cfg[i] <= factory(i);
            end
        end else if (wr_en_i && wr_hit) begin
            cfg[wr_idx[3:0]] <= wr_data_i;
        end
    end

    // read mux, zero when outside the set
    always @* begin
        rd_data_o = rd_hit ? cfg[rd_idx[3:0]] : `PCR_DEF_ZERO;
    end

    assign feature_o  = cfg[0];
    assign fallback_o = cfg[3];
endmodule // pcr_channel_bank

// ===== rtl/pcr_param_bank.v
// two-channel parameter and command register bank reached by control-byte access
// What this block does
// - commands run only while the protection key holds 0x1235
// - command 0x7000 reloads all configuration registers with factory values
// - factory restore acts on both channel register sets together
// - command 0x8000 performs a software reset of internal state, configuration registers keep their values
// - output stage is undriven until reinitialisation after software reset ends
// - identification register reads a fixed variant code
// - firmware version reads two ascii characters and ignores writes
// - configuration writes are discarded unless the key holds 0x1235
// - protection key clears on every restart
// - feature bit 15 disables mixed decay
// - feature bit 8 enables the fallback switch-on value
// - feature bit 6 enables setpoint ramps timed in 1 ms units
// - dither runs only with feature bit 5 and control bit 0 set
// - feature bit 4 applies the valve curve registers
// - feature bit 3 selects sign-magnitude setpoint format
// - feature bit 2 disables the 100 ms bus watchdog
// - feature bits 1 and 0 enable factory and user scaling
// - tripped watchdog with fallback enabled drives the stored fallback value
// - current limit holds milliamps, ceiling set by variant
// - dither amplitude is in percent of the current limit
// - dither fade time is in 1 ms units
// - control byte: bit 7 access, bit 6 write, bits 5..0 register
// - status byte echoes control byte, write clears bit 6
// - changed feature word takes effect only after restart, fallback value at once
`timescale 1ns/1ps
`include "pcr_regs.vh"
module pcr_param_bank #(
    parameter [15:0] VARIANT_ID     = 16'h0a5a,
    parameter [15:0] FW_VERSION     = 16'h3130,
    parameter [15:0] HW_VERSION     = 16'h0001,
    parameter [15:0] CUR_LIMIT_DEF  = 16'h03e8,
    parameter [23:0] WDOG_CYCLES    = `PCR_WDOG_CYCLES
) (
    input  wire        core_clk_i,
    input  wire        nrst_i,
    input  wire        ch_sel_i,
    input  wire        req_valid_i,
    input  wire [7:0]  ctrl_byte_i,
    input  wire [15:0] data_out_i,
    input  wire        dither_gate_control_bit_i,
    input  wire        bus_ok_i,
    output reg  [7:0]  status_byte_o,
    output reg  [15:0] data_in_o,
    output reg         resp_valid_o,
    output reg         drive_enable_o,
    output reg         sw_reset_o,
    output reg  [1:0]  mixed_decay_off_o,
    output reg  [1:0]  fallback_active_o,
    output reg  [1:0]  setpoint_ramp_on_o,
    output reg  [1:0]  dither_on_o,
    output reg  [1:0]  valve_curve_on_o,
    output reg  [1:0]  sign_magnitude_select_o,
    output reg  [1:0]  bus_watchdog_off_o,
    output reg  [1:0]  factory_scaling_on_o,
    output reg  [1:0]  user_scaling_on_o,
    output reg  [31:0] fallback_value_o
);
    // shared words: key, command, ids
    // per-channel words: 0x20 to 0x2e
    // ch_sel_i picks the channel set
    // bus is a control byte plus a word
    // writes need run state, all but key writes also the key
    // reads are answered at all times
    // each access echoes next cycle
    // restore reloads both sets at once
    // swreset clears the key
    // swreset holds the output stage off
    // features act only after restart
    // hazards a user must know:
    // - writes in reinit are dropped
    // - dropped writes are still echoed
    // - unknown commands only stored
    // - fallback words pass live
    // - wrong key value relocks
    // sequencer states
    localparam ST_RUN    = 1'b0;
    localparam ST_REINIT = 1'b1;

    reg  [15:0] key;
    reg  [15:0] command_entry;
    reg         state;
    reg  [4:0]  reinit_cnt;
    reg  [23:0] wdog_cnt;
    reg  [1:0]  wdog_trip;
    reg  [15:0] live_feature [0:1];
    wire [15:0] rd_ch0;
    wire [15:0] rd_ch1;
    wire [15:0] feat0;
    wire [15:0] feat1;
    wire [15:0] fb0;
    wire [15:0] fb1;
    // request decode, all combinational
    // from the request cycle inputs
    wire        access   = req_valid_i && ctrl_byte_i[`PCR_CB_ACCESS];
    wire        is_write = access && ctrl_byte_i[`PCR_CB_WRITE];
    wire        is_read  = access && !ctrl_byte_i[`PCR_CB_WRITE];
    wire [5:0]  reg_num  = ctrl_byte_i[5:0];
    wire        unlocked = (key == `PCR_KEY_VALUE);
    wire        cfg_wr   = is_write && unlocked && (state == ST_RUN);
    wire        cmd_wr   = cfg_wr && (reg_num == `PCR_REG_COMMAND);
    wire        restore  = cmd_wr && (data_out_i == `PCR_CMD_RESTORE);
    wire        swreset  = cmd_wr && (data_out_i == `PCR_CMD_SWRESET);
    wire        wr_ch0   = cfg_wr && !ch_sel_i;
    wire        wr_ch1   = cfg_wr && ch_sel_i;
    reg         live_load;
    integer     c;
    integer     d;

    // both sets share the register number
    // only the write enable differs
    // reads come from both sets
    // the read mux picks by ch_sel_i
    // channel register sets, both reached by one restore strobe
    pcr_channel_bank #(
        .CUR_LIMIT_DEF (CUR_LIMIT_DEF)
    ) u_bank0 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .wr_en_i    (wr_ch0),
        .wr_reg_i   (reg_num),
        .wr_data_i  (data_out_i),
        .restore_i  (restore),
        .rd_reg_i   (reg_num),
        .rd_data_o  (rd_ch0),
        .feature_o  (feat0),
        .fallback_o (fb0)
    );

    pcr_channel_bank #(
        .CUR_LIMIT_DEF (CUR_LIMIT_DEF)
    ) u_bank1 (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .wr_en_i    (wr_ch1),
        .wr_reg_i   (reg_num),
        .wr_data_i  (data_out_i),
        .restore_i  (restore),
        .rd_reg_i   (reg_num),
        .rd_data_o  (rd_ch1),
        .feature_o  (feat1),
        .fallback_o (fb1)
    );

    // key gates config writes and commands
    // any key write replaces the key
    // so a wrong value locks again
    // key writes refused in reinit
    // swreset clears it in its own cycle
    // command word is readback only
    // actions come from the strobes
    // restore wins over a plain write
    // inside each channel set
    // protection key and command register
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            key           <= 16'h0000;
            command_entry <= 16'h0000;
        end else if (swreset) begin
            // software reset is a restart too
            key           <= 16'h0000;
            command_entry <= 16'h0000;
        end else if (is_write && reg_num == `PCR_REG_KEY && state == ST_RUN) begin
            key <= data_out_i;
        end else if (cmd_wr) begin
            command_entry <= data_out_i;
        end
    end

    // power-on reset starts in reinit
    // reinit lasts 16 cycles, drive off
    // swreset enters at count one:
    // its own cycle already has
    // the output stage switched off
    // live_load pulses at the end
    // and takes the feature words
    // reads stay answered meanwhile
    // reinitialisation sequence after software reset
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state      <= ST_REINIT;
            reinit_cnt <= 5'h00;
            live_load  <= 1'b1;
        end else begin
            live_load <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (swreset) begin
                        state      <= ST_REINIT;
                        reinit_cnt <= 5'h01;
                    end
                end
                ST_REINIT: begin
                    if (reinit_cnt == `PCR_REINIT_CYCLES - 1) begin
                        state     <= ST_RUN;
                        live_load <= 1'b1;
                    end else begin
                        reinit_cnt <= reinit_cnt + 5'h01;
                    end
                end
                default: begin
                    state <= ST_REINIT;
                end
            endcase
        end
    end

    // both channels latch together
    // reset value is all features off
    // until the first restart end
    // feature values sampled at the first edge after reset and at restart end
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            live_feature[0] <= 16'h0000;
            live_feature[1] <= 16'h0000;
        end else if (live_load) begin
            live_feature[0] <= feat0;
            live_feature[1] <= feat1;
        end
    end

    // counts cycles of bad bus traffic
    // healthy traffic restarts the count
    // reinit restarts it as well
    // expiry trips each channel
    // unless its watchdog is off
    // trip holds until traffic returns or reinit
    // limit is a parameter for benches
    // bus watchdog, trip latch
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wdog_cnt  <= 24'h000000;
            wdog_trip <= 2'b00;
        end else if (bus_ok_i || state == ST_REINIT) begin
            wdog_cnt  <= 24'h000000;
            wdog_trip <= 2'b00;
        end else if (wdog_cnt < WDOG_CYCLES - 24'h000001) begin
            wdog_cnt <= wdog_cnt + 24'h000001;
        end else begin
            for (d = 0; d < 2; d = d + 1) begin
                wdog_trip[d] <= !live_feature[d][`PCR_FB_WDOG_OFF];
            end
        end
    end

    // feature outputs use latched features
    // not the stored words, so a change
    // waits for the next restart
    // dither also needs the gate bit
    // the gate bit is taken each cycle
    // fallback needs enable and trip
    // drive drops in the swreset cycle
    // feature decode to the output stage
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mixed_decay_off_o       <= 2'b00;
            fallback_active_o       <= 2'b00;
            setpoint_ramp_on_o      <= 2'b00;
            dither_on_o             <= 2'b00;
            valve_curve_on_o        <= 2'b00;
            sign_magnitude_select_o <= 2'b00;
            bus_watchdog_off_o      <= 2'b00;
            factory_scaling_on_o    <= 2'b00;
            user_scaling_on_o       <= 2'b00;
            fallback_value_o        <= 32'h00000000;
            drive_enable_o          <= 1'b0;
            sw_reset_o              <= 1'b0;
        end else begin
            for (c = 0; c < 2; c = c + 1) begin
                mixed_decay_off_o[c]       <= live_feature[c][`PCR_FB_MIXED_OFF];
                fallback_active_o[c]       <= live_feature[c][`PCR_FB_FALLBACK_ON]
                                              && wdog_trip[c];
                setpoint_ramp_on_o[c]      <= live_feature[c][`PCR_FB_RAMP_ON];
                dither_on_o[c]             <= live_feature[c][`PCR_FB_DITHER_ON]
                                              && dither_gate_control_bit_i;
                valve_curve_on_o[c]        <= live_feature[c][`PCR_FB_CURVE_ON];
                sign_magnitude_select_o[c] <= live_feature[c][`PCR_FB_SIGN_MAG];
                bus_watchdog_off_o[c]      <= live_feature[c][`PCR_FB_WDOG_OFF];
                factory_scaling_on_o[c]    <= live_feature[c][`PCR_FB_FACT_SCALE];
                user_scaling_on_o[c]       <= live_feature[c][`PCR_FB_USER_SCALE];
            end
            fallback_value_o <= {fb1, fb0};
            drive_enable_o   <= (state == ST_RUN) && !swreset;
            sw_reset_o       <= (state == ST_REINIT) || swreset;
        end
    end

    // one access per request pulse
    // answered on the next edge
    // status repeats the control byte
    // bit 6 cleared for a write
    // read data loads on reads only
    // and stands until the next read
    // channel words from ch_sel_i set
    // unmapped numbers read as zero
    // no access bit: echo only
    // access decode, status echo and read data
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_byte_o <= 8'h00;
            data_in_o     <= 16'h0000;
            resp_valid_o  <= 1'b0;
        end else begin
            resp_valid_o <= access;
            if (is_write) begin
                status_byte_o <= ctrl_byte_i & 8'hbf;
            end else if (is_read) begin
                status_byte_o <= ctrl_byte_i;
                case (reg_num)
                    `PCR_REG_COMMAND:    data_in_o <= command_entry;
                    `PCR_REG_VARIANT:    data_in_o <= VARIANT_ID;
                    `PCR_REG_FW_VERSION: data_in_o <= FW_VERSION;
                    `PCR_REG_HW_VERSION: data_in_o <= HW_VERSION;
                    `PCR_REG_KEY:        data_in_o <= key;
                    default:             data_in_o <= ch_sel_i ? rd_ch1 : rd_ch0;
                endcase
            end else if (req_valid_i) begin
                status_byte_o <= ctrl_byte_i;
            end
        end
    end
endmodule // pcr_param_bank

// ===== rtl/pcr_regs.vh
// register numbers, field positions, factory values and command codes of the parameter bank
`ifndef PCR_REGS_VH
`define PCR_REGS_VH
`define PCR_REG_COMMAND      6'h07
`define PCR_REG_VARIANT      6'h08
`define PCR_REG_FW_VERSION   6'h09
`define PCR_REG_HW_VERSION   6'h10
`define PCR_REG_KEY          6'h1f
`define PCR_REG_FEATURE      6'h20
`define PCR_REG_USER_OFFSET  6'h21
`define PCR_REG_USER_GAIN    6'h22
`define PCR_REG_FALLBACK     6'h23
`define PCR_REG_CUR_LIMIT    6'h24
`define PCR_REG_DITH_FREQ    6'h25
`define PCR_REG_DITH_AMPL    6'h26
`define PCR_REG_DITH_FADE    6'h27
`define PCR_REG_OVL_THR      6'h28
`define PCR_REG_OVL_OUT      6'h29
`define PCR_REG_BEND_THR     6'h2a
`define PCR_REG_BEND_OUT     6'h2b
`define PCR_REG_AREA_THR     6'h2c
`define PCR_REG_RAMP_RISE    6'h2d
`define PCR_REG_RAMP_FALL    6'h2e
`define PCR_CFG_FIRST        6'h20
`define PCR_CFG_COUNT        15
`define PCR_KEY_VALUE        16'h1235
`define PCR_CMD_RESTORE      16'h7000
`define PCR_CMD_SWRESET      16'h8000
`define PCR_DEF_ZERO         16'h0000
`define PCR_DEF_GAIN         16'h1000
`define PCR_DEF_AREA         16'h03e8
`define PCR_CB_ACCESS        7
`define PCR_CB_WRITE         6
`define PCR_FB_MIXED_OFF     15
`define PCR_FB_FALLBACK_ON   8
`define PCR_FB_RAMP_ON       6
`define PCR_FB_DITHER_ON     5
`define PCR_FB_CURVE_ON      4
`define PCR_FB_SIGN_MAG      3
`define PCR_FB_WDOG_OFF      2
`define PCR_FB_FACT_SCALE    1
`define PCR_FB_USER_SCALE    0
`define PCR_WDOG_TIMEOUT_MS  100
`define PCR_CLK_KHZ          100000
`define PCR_WDOG_CYCLES      24'd10000000
`define PCR_REINIT_CYCLES    16
`endif

// ===== verif/pcr_coupler_model.sv
// coupler model issuing control-byte register accesses
`timescale 1ns/1ps
module pcr_coupler_model (
    input  wire        core_clk_i,
    input  wire        resp_valid_i,
    input  wire [7:0]  status_byte_i,
    input  wire [15:0] data_in_i,
    output reg         req_valid_o,
    output reg         ch_sel_o,
    output reg  [7:0]  ctrl_byte_o,
    output reg  [15:0] data_out_o
);
    reg [7:0]  st;
    reg [15:0] rdat;
    reg        ok;
    // idle lines at time zero
    initial begin
        req_valid_o = 1'b0;
        ch_sel_o = 1'b0;
        ctrl_byte_o = 8'h00;
        data_out_o = 16'h0000;
    end
    // request for one cycle, answer taken when it is flagged
    // access bit, write bit, register
    task xfer(input w, input ch, input [5:0] r, input [15:0] d);
        integer n;
        begin
            @(posedge core_clk_i);
            req_valid_o <= 1'b1;
            ch_sel_o    <= ch;
            ctrl_byte_o <= {1'b1, w, r};
            data_out_o  <= d;
            @(posedge core_clk_i);
            req_valid_o <= 1'b0;
            ctrl_byte_o <= ~ctrl_byte_o;  // released lines lose their value
            data_out_o  <= ~data_out_o;
            ok = 1'b0;
            for (n = 0; n < 4 && !ok; n = n + 1) begin
                @(posedge core_clk_i);
                ok = resp_valid_i;
            end
            st = status_byte_i;
            rdat = data_in_i;
        end
    endtask
endmodule // pcr_coupler_model

// ===== verif/pcr_param_bank_props.sv
// port assertions for the parameter bank
`timescale 1ns/1ps
`include "pcr_regs.vh"
module pcr_param_bank_props #(
    parameter [15:0] VARIANT_ID = 16'h0000,
    parameter [15:0] FW_VERSION = 16'h0000
) (
    input wire        core_clk_i,
    input wire        nrst_i,
    input wire        req_valid_i,
    input wire [7:0]  ctrl_byte_i,
    input wire [15:0] data_out_i,
    input wire        dither_gate_control_bit_i,
    input wire [7:0]  status_byte_o,
    input wire [15:0] data_in_o,
    input wire        resp_valid_o,
    input wire        drive_enable_o,
    input wire        sw_reset_o,
    input wire [1:0]  dither_on_o,
    input wire [1:0]  fallback_active_o,
    input wire [1:0]  bus_watchdog_off_o
);
    reg  key_ok;
    wire acc = req_valid_i && ctrl_byte_i[7];
    wire wr  = acc && ctrl_byte_i[6];
    wire rq  = acc && !ctrl_byte_i[6];
    wire rd8 = rq && ctrl_byte_i[5:0] == 6'h08;
    wire rd9 = rq && ctrl_byte_i[5:0] == 6'h09;
    wire cmd = wr && ctrl_byte_i[5:0] == 6'h07 && data_out_i == `PCR_CMD_SWRESET;
    // key as last written outside reinit
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i)
            key_ok <= 1'b0;
        else if (sw_reset_o)
            key_ok <= 1'b0;
        else if (wr && ctrl_byte_i[5:0] == 6'h1f)
            key_ok <= data_out_i == `PCR_KEY_VALUE;
    end
    default clocking dc @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    a_resp_after_req: assert property (acc |=> resp_valid_o)
        else $error("missing response");
    a_resp_only_req: assert property (!acc |=> !resp_valid_o)
        else $error("stray response");
    a_status_echo:
        assert property (acc |=> status_byte_o == ($past(ctrl_byte_i) & 8'hbf))
        else $error("bad echo");
    a_variant_read: assert property (rd8 |=> data_in_o == VARIANT_ID)
        else $error("bad variant code");
    a_fw_read: assert property (rd9 |=> data_in_o == FW_VERSION)
        else $error("bad firmware code");
    a_drive_off: assert property (sw_reset_o |-> !drive_enable_o)
        else $error("driven in reinit");
    a_reinit_span:
        assert property ($rose(sw_reset_o) |-> sw_reset_o[*8] ##1 sw_reset_o[*8] ##1 !sw_reset_o)
        else $error("reinit length");
    a_swreset_start: assert property (cmd && key_ok && !sw_reset_o |=> sw_reset_o)
        else $error("reset not started");
    a_cmd_key_gate: assert property (cmd && !key_ok && !sw_reset_o |=> !sw_reset_o)
        else $error("command without key");
    a_dither_gated:
        assert property (dither_on_o != 2'b00 |->
            dither_gate_control_bit_i || $past(dither_gate_control_bit_i))
        else $error("dither without gate");
    a_fallback_wdog:
        assert property ((fallback_active_o & bus_watchdog_off_o) == 2'b00)
        else $error("fallback with watchdog off");
    c_swreset: cover property (cmd && key_ok);
    c_fallback: cover property (fallback_active_o != 2'b00);
    c_dither: cover property (dither_on_o != 2'b00);
endmodule // pcr_param_bank_props
bind pcr_param_bank pcr_param_bank_props #(.VARIANT_ID(VARIANT_ID), .FW_VERSION(FW_VERSION))
    u_props (.core_clk_i, .nrst_i, .req_valid_i, .ctrl_byte_i, .data_out_i,
    .dither_gate_control_bit_i, .status_byte_o, .data_in_o, .resp_valid_o, .drive_enable_o,
    .sw_reset_o, .dither_on_o, .fallback_active_o, .bus_watchdog_off_o);

// ===== verif/pcr_param_bank_tb_top.sv
// self-checking bench of the parameter bank
`timescale 1ns/1ps
module pcr_param_bank_tb_top;
    localparam [15:0] LIM = 16'h0dac;
    localparam [15:0] VID = 16'h0c3c;  // arbitrary variant code
    localparam [15:0] FWV = 16'h3242;
    localparam [15:0] HWV = 16'h0002;
    reg         core_clk_i;
    reg         nrst_i;
    reg         dither_gate_control_bit_i;
    reg         bus_ok_i;
    wire        req_valid_i, ch_sel_i, resp_valid_o, drive_enable_o, sw_reset_o;
    wire [7:0]  ctrl_byte_i, status_byte_o;
    wire [15:0] data_out_i, data_in_o;
    wire [31:0] fallback_value_o;
    wire [1:0]  mixed_decay_off_o, fallback_active_o, setpoint_ramp_on_o, dither_on_o;
    wire [1:0]  valve_curve_on_o, sign_magnitude_select_o, bus_watchdog_off_o;
    wire [1:0]  factory_scaling_on_o, user_scaling_on_o;
    reg  [15:0] exp_cfg [0:1][0:14];
    reg  [15:0] v;
    integer     num_errors, n_compared, c, i, n;

    pcr_param_bank #(.VARIANT_ID(VID), .FW_VERSION(FWV), .CUR_LIMIT_DEF(LIM), .HW_VERSION(HWV),
        .WDOG_CYCLES(24'd50)) dut (.core_clk_i, .nrst_i, .ch_sel_i, .req_valid_i,
        .ctrl_byte_i, .data_out_i, .dither_gate_control_bit_i, .bus_ok_i, .status_byte_o,
        .data_in_o, .resp_valid_o, .drive_enable_o, .sw_reset_o, .mixed_decay_off_o,
        .fallback_active_o, .setpoint_ramp_on_o, .dither_on_o, .valve_curve_on_o,
        .sign_magnitude_select_o, .bus_watchdog_off_o, .factory_scaling_on_o,
        .user_scaling_on_o, .fallback_value_o);
    pcr_coupler_model cpl (.core_clk_i, .resp_valid_i(resp_valid_o),
        .status_byte_i(status_byte_o), .data_in_i(data_in_o), .req_valid_o(req_valid_i),
        .ch_sel_o(ch_sel_i), .ctrl_byte_o(ctrl_byte_i), .data_out_o(data_out_i));

    // 100 MHz core clock
    always #5 core_clk_i = ~core_clk_i;

    task tally_and_finish;
        begin
            if (num_errors == 0 && n_compared > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task bail;
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED t=%0t wait ran out", $time);
            tally_and_finish;
        end
    endtask
    task chk_word(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED t=%0t word %h not %h", $time, got, exp);
            end
        end
    endtask
    task chk_out(input [15:0] got, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED t=%0t pins %h not %h", $time, got, exp);
            end
        end
    endtask
    function [15:0] cfg_def(input integer k);
        cfg_def = (k == 2) ? 16'h1000 : (k == 4) ? LIM : (k == 12) ? 16'h03e8 : 16'h0000;
    endfunction
    task set_defaults;
        for (c = 0; c < 2; c = c + 1)
            for (i = 0; i < 15; i = i + 1)
                exp_cfg[c][i] = cfg_def(i);
    endtask
    task acc(input w, input ch, input [5:0] r, input [15:0] d);
        begin
            cpl.xfer(w, ch, r, d);
            if (!cpl.ok)
                bail;
            chk_word(cpl.st, {24'h0, 2'b10, r});
        end
    endtask
    task rd(input ch, input [5:0] r, input [15:0] e);
        begin
            acc(1'b0, ch, r, 16'h0000);
            chk_word(cpl.rdat, e);
        end
    endtask
    task chk_all;
        for (c = 0; c < 2; c = c + 1)
            for (i = 0; i < 15; i = i + 1)
                rd(c[0], 6'h20 + i[5:0], exp_cfg[c][i]);
    endtask
    task wait_run;
        begin
            n = 0;
            while (sw_reset_o !== 1'b0 && n < 40) begin
                @(posedge core_clk_i);
                n = n + 1;
            end
            if (n == 40)
                bail;
            #1;
        end
    endtask

    // main sequence
    initial begin
        core_clk_i = 1'b0;
        nrst_i = 1'b0;
        dither_gate_control_bit_i = 1'b0;
        bus_ok_i = 1'b1;
        num_errors = 0;
        n_compared = 0;
        v = $urandom(32'h5e10);
        set_defaults;
        repeat (8) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        wait_run;
        chk_all;
        rd(1'b0, 6'h08, VID);
        acc(1'b1, 1'b0, 6'h09, 16'h0000);
        rd(1'b1, 6'h09, FWV);
        rd(1'b0, 6'h30, 16'h0000);
        acc(1'b1, 1'b0, 6'h20, 16'hffff);
        rd(1'b0, 6'h20, 16'h0000);
        rd(1'b1, 6'h1f, 16'h0000);
        acc(1'b1, 1'b0, 6'h1f, 16'h1235);
        rd(1'b0, 6'h1f, 16'h1235);
        acc(1'b1, 1'b0, 6'h09, 16'h0000);
        rd(1'b1, 6'h09, FWV);
        rd(1'b0, 6'h10, HWV);
        for (n = 0; n < 40; n = n + 1) begin
            c = $urandom % 2;
            i = $urandom % 15;
            v = $urandom;
            if (i == 5)
                v = 16'(10 + $urandom % 491);
            if (i == 4)
                v = 16'($urandom % (LIM + 1));
            acc(1'b1, c[0], 6'h20 + i[5:0], v);
            exp_cfg[c][i] = v;
        end
        chk_all;
        acc(1'b1, 1'b0, 6'h07, 16'h7001);
        #1 chk_out({sw_reset_o, drive_enable_o}, 16'h1);
        rd(1'b0, 6'h07, 16'h7001);
        acc(1'b1, 1'b1, 6'h07, 16'h7000);
        set_defaults;
        chk_all;
        acc(1'b1, 1'b0, 6'h1f, 16'h1235);
        acc(1'b1, 1'b0, 6'h20, 16'h817b);
        acc(1'b1, 1'b1, 6'h20, 16'h0104);
        acc(1'b1, 1'b0, 6'h23, 16'h0123);
        acc(1'b1, 1'b1, 6'h23, 16'h0abc);
        #1 chk_out(mixed_decay_off_o, 16'h0);
        acc(1'b1, 1'b1, 6'h07, 16'h8000);
        #1 chk_out({sw_reset_o, drive_enable_o}, 16'h2);
        wait_run;
        chk_out({sw_reset_o, drive_enable_o}, 16'h1);
        chk_out({mixed_decay_off_o, setpoint_ramp_on_o, valve_curve_on_o,
            sign_magnitude_select_o, bus_watchdog_off_o, factory_scaling_on_o,
            user_scaling_on_o}, 16'h1565);
        chk_out({dither_on_o, fallback_active_o}, 16'h0);
        rd(1'b0, 6'h1f, 16'h0000);
        acc(1'b1, 1'b0, 6'h07, 16'h8000);
        #1 chk_out({sw_reset_o, drive_enable_o}, 16'h1);
        @(posedge core_clk_i);
        dither_gate_control_bit_i <= 1'b1;
        bus_ok_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1 chk_out(dither_on_o, 16'h1);
        repeat (37) @(posedge core_clk_i);
        #1 chk_out(fallback_active_o, 16'h0);
        repeat (20) @(posedge core_clk_i);
        #1 chk_out(fallback_active_o, 16'h1);
        chk_word(fallback_value_o, 32'h0abc0123);
        tally_and_finish;
    end
endmodule // pcr_param_bank_tb_top
